/* rtl/cmd_port_pkg.sv */
/*
 command port package: slot layout, address map constants, carriers, states.
 assumes a 32-bit word slave bus with a one-cycle handshake.
*/
package cmd_port_pkg;
	localparam int unsigned NUM_SLOTS      = 4;
	localparam int unsigned SLOT_W         = 2;
	localparam int unsigned NUM_IRQ        = 8;
	localparam int unsigned IRQ_W          = 3;
	// command word fields
	localparam int unsigned OCC_BIT        = 31;
	localparam int unsigned FIN_BIT        = 30;
	localparam int unsigned ERR_BIT        = 29;
	localparam int unsigned TYPE_LSB       = 9;
	localparam int unsigned TYPE_W         = 6;
	localparam int unsigned IMM_W          = 9;
	localparam int unsigned LOW_CMD_W      = 15;
	localparam int unsigned CTX_SEL_LSB    = 0;
	// address map inside the 256 KiB region
	localparam int unsigned REGION_AW      = 18;
	localparam int unsigned PAGE_LSB       = 12;
	localparam int unsigned ISSUE_ADDR_LSB = 3;
	localparam logic [11:0] CTRL_IRQ_BASE  = 12'h100;
	localparam logic [11:0] CTRL_CTX_LO    = 12'h104;
	localparam logic [11:0] CTRL_CTX_HI    = 12'h108;
	localparam logic [11:0] CTRL_INT_MASK  = 12'h10c;
	localparam logic [11:0] CTRL_INT_REQ   = 12'h110;
	localparam logic [31:0] RST_WORD       = 32'h0000_0000;
	localparam logic [31:0] NO_SLOT        = 32'hffff_ffff;
	localparam logic [31:0] EVT_READY      = 32'h0000_0001;
	localparam logic [15:0] CTX_ZERO       = 16'h0000;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAKE = 2'b01,
		ST_EXEC = 2'b11,
		ST_IRQ  = 2'b10
	} cp_state_t;

	typedef struct packed {
		logic        req;
		logic [31:0] addr;
		logic [31:0] data;
		logic [15:0] ctx;
	} set_event_t;

	typedef struct packed {
		logic        req;
		logic [5:0]  ctype;
		logic [8:0]  imm;
		logic [31:0] data;
		logic [15:0] ctx;
		logic [SLOT_W-1:0] slot;
	} cmd_req_t;

	typedef struct packed {
		logic        valid;
		logic        err;
		logic [31:0] data;
	} cmd_done_t;
endpackage : cmd_port_pkg

/* rtl/slot_picker.sv */
/*
 round-robin picker: first set bit of a vector at or after a start index.
 assumes pure combinational use within the command port clock domain.
*/
`timescale 1ns/1ns
module slot_picker
	import cmd_port_pkg::*;
(
	input  wire logic [NUM_SLOTS-1:0] i_vec,
	input  wire logic [SLOT_W-1:0]    i_start,
	output logic                      o_found,
	output logic [SLOT_W-1:0]         o_idx
);
	always_comb begin
		logic [SLOT_W-1:0] k;
		k       = '0;
		o_found = 1'b0;
		o_idx   = '0;
		for (int i = NUM_SLOTS - 1; i >= 0; i--) begin
			k = i_start + SLOT_W'(i);
			if (i_vec[k]) begin
				o_found = 1'b1;
				o_idx   = k;
			end
		end
	end
endmodule : slot_picker

/* rtl/command_port_processor.sv */
/*
 command port processor: slot pairs, guarded issue image, round-robin command
 dispatch, and masked interrupts turned into set-event requests.
 assumes a word slave bus answered one cycle later, a command executor that
 answers each dispatch with a done pulse, and a memory agent for set-events.
*/
// Behaviour
// - wake on pending interrupt or occupied slot
// - classify wake cause before any other work
// - write result data, then clear occupied
// - two-bit selector picks a sixteen-bit context
// - four contexts held in double-length register
// - event location at base plus twice n words
// - interrupt taken when request AND mask
// - slot is data word plus command word
// - command word bit layout fixed
// - issue read gives free slot or negative
// - issue write fills free slot, address gives command
// - issue write when full acknowledged, no change
// - state changes only on writes
// - swap samples occupancy once for both halves
// - slots run in round-robin submission order
// - page zero direct, later pages issue types
// - set-event in context zero, mask off, deactivate
// - only four exception kinds raised
// - unimplemented command types not trapped
// - set-event on idle location sets ready bit
`timescale 1ns/1ns
module command_port_processor
	import cmd_port_pkg::*;
(
	input  wire logic              i_clk,
	input  wire logic              i_rst_n,
	input  wire logic              i_bus_sel,
	input  wire logic              i_bus_wr,
	input  wire logic              i_bus_rmw,
	input  wire logic [3:0]        i_bus_be,
	input  wire logic [REGION_AW-1:0] i_bus_addr,
	input  wire logic [31:0]       i_bus_wdata,
	output logic                   o_bus_ack,
	output logic [31:0]            o_bus_rdata,
	input  wire logic [NUM_IRQ-1:0] i_int_req,
	output cmd_req_t               o_cmd,
	input  wire cmd_done_t         i_done,
	output set_event_t             o_set_event,
	input  wire logic              i_set_event_ack,
	input  wire logic              i_exc_data_access,
	input  wire logic              i_exc_event_int,
	input  wire logic              i_exc_queue_ovf,
	input  wire logic              i_exc_misaligned,
	output logic [3:0]             o_exception,
	output logic [NUM_SLOTS-1:0]   o_slot_occupied,
	output logic                   o_busy
);
	logic [31:0]          data_ff [NUM_SLOTS];
	logic [31:0]          nxt_data [NUM_SLOTS];
	logic [NUM_SLOTS-1:0] occ_ff, nxt_occ, fin_ff, nxt_fin, err_ff, nxt_err;
	logic [14:0]          low_ff [NUM_SLOTS];
	logic [14:0]          nxt_low [NUM_SLOTS];
	logic [31:0]          irq_base_ff, nxt_irq_base;
	logic [63:0]          ctx_vec_ff, nxt_ctx_vec;
	logic [NUM_IRQ-1:0]   int_mask_ff, nxt_int_mask;
	logic [NUM_IRQ-1:0]   int_sync1_ff, int_sync2_ff, int_sync3_ff, int_ff;
	logic [NUM_IRQ-1:0]   nxt_int;
	cp_state_t            state_ff, nxt_state;
	logic [SLOT_W-1:0]    rr_ff, nxt_rr, cur_ff, nxt_cur;
	logic [IRQ_W-1:0]     irq_ff, nxt_irq;
	logic                 ack_ff, nxt_ack;
	logic [31:0]          rdata_ff, nxt_rdata;
	cmd_req_t             cmd_ff, nxt_cmd;
	set_event_t           sev_ff, nxt_sev;
	logic [3:0]           exc_ff, nxt_exc;
	logic                 swap_ff, nxt_swap, swap_found_ff, nxt_swap_found;
	logic [SLOT_W-1:0]    swap_idx_ff, nxt_swap_idx;
	logic                 busy_ff, nxt_busy;

	logic                 free_found, run_found;
	logic [SLOT_W-1:0]    free_idx, run_idx;
	logic [NUM_IRQ-1:0]   taken;
	logic                 direct, wr_ok;
	logic [SLOT_W-1:0]    dslot;
	logic                 wr_found;
	logic [SLOT_W-1:0]    wr_idx;

	function automatic logic [31:0] cmd_word(input logic o, input logic f, input logic e,
		input logic [14:0] low);
		cmd_word = {o, f, e, 14'h0000, low};
	endfunction : cmd_word

	function automatic logic [15:0] ctx_pick(input logic [63:0] vec, input logic [1:0] sel);
		ctx_pick = vec[16*sel +: 16];
	endfunction : ctx_pick

	// issue writes fill the first free slot at or after the one following the last completed, keeping order
	slot_picker u_free (
		.i_vec   (~occ_ff),
		.i_start (rr_ff),
		.o_found (free_found),
		.o_idx   (free_idx)
	);

	slot_picker u_run (
		.i_vec   (occ_ff),
		.i_start (rr_ff),
		.o_found (run_found),
		.o_idx   (run_idx)
	);

	assign taken  = int_ff & int_mask_ff;
	assign direct = (i_bus_addr[REGION_AW-1:PAGE_LSB] == '0);
	assign dslot  = i_bus_addr[SLOT_W+2:3];
	assign wr_ok  = i_bus_sel & i_bus_wr & (i_bus_be == 4'hf);
	// a swap write reuses the slot its own read reported, even if a completion came between
	assign wr_found = (i_bus_rmw && swap_ff) ? swap_found_ff : free_found;
	assign wr_idx   = (i_bus_rmw && swap_ff) ? swap_idx_ff : free_idx;

	// bus side and slot store
	always_comb begin
		nxt_data     = data_ff;
		nxt_occ      = occ_ff;
		nxt_fin      = fin_ff;
		nxt_err      = err_ff;
		nxt_low      = low_ff;
		nxt_irq_base = irq_base_ff;
		nxt_ctx_vec  = ctx_vec_ff;
		nxt_ack      = i_bus_sel;
		nxt_rdata    = '0;
		nxt_swap       = swap_ff & ~i_bus_sel;
		nxt_swap_found = swap_found_ff;
		nxt_swap_idx   = swap_idx_ff;
		if (i_bus_sel && !i_bus_wr) begin
			if (!direct) begin
				nxt_rdata = free_found ? 32'(free_idx) : NO_SLOT;
				if (i_bus_rmw) begin
					nxt_swap       = 1'b1;
					nxt_swap_found = free_found;
					nxt_swap_idx   = free_idx;
				end
			end else if (i_bus_addr[11:PAGE_LSB-4] == '0 && dslot < SLOT_W'(NUM_SLOTS - 1) + 1) begin
				nxt_rdata = i_bus_addr[2] ?
					cmd_word(occ_ff[dslot], fin_ff[dslot], err_ff[dslot], low_ff[dslot])
					: data_ff[dslot];
			end else begin
				unique case (i_bus_addr[11:0])
					CTRL_IRQ_BASE: nxt_rdata = irq_base_ff;
					CTRL_CTX_LO:   nxt_rdata = ctx_vec_ff[31:0];
					CTRL_CTX_HI:   nxt_rdata = ctx_vec_ff[63:32];
					CTRL_INT_MASK: nxt_rdata = 32'(int_mask_ff);
					CTRL_INT_REQ:  nxt_rdata = 32'(int_ff);
					default:       nxt_rdata = '0;
				endcase
			end
		end
		if (wr_ok && !direct && wr_found) begin
			nxt_data[wr_idx] = i_bus_wdata;
			nxt_occ[wr_idx]  = 1'b1;
			nxt_fin[wr_idx]  = 1'b0;
			nxt_err[wr_idx]  = 1'b0;
			nxt_low[wr_idx]  = i_bus_addr[REGION_AW-1:ISSUE_ADDR_LSB];
		end else if (wr_ok && direct && i_bus_addr[11:PAGE_LSB-4] == '0) begin
			if (i_bus_addr[2]) begin
				nxt_occ[dslot] = i_bus_wdata[OCC_BIT];
				nxt_fin[dslot] = i_bus_wdata[FIN_BIT];
				nxt_err[dslot] = i_bus_wdata[ERR_BIT];
				nxt_low[dslot] = i_bus_wdata[LOW_CMD_W-1:0];
			end else begin
				nxt_data[dslot] = i_bus_wdata;
			end
		end else if (wr_ok && direct) begin
			unique case (i_bus_addr[11:0])
				CTRL_IRQ_BASE: nxt_irq_base = i_bus_wdata;
				CTRL_CTX_LO:   nxt_ctx_vec[31:0] = i_bus_wdata;
				CTRL_CTX_HI:   nxt_ctx_vec[63:32] = i_bus_wdata;
				default:       nxt_irq_base = irq_base_ff;
			endcase
		end
		if (i_done.valid && state_ff == ST_EXEC) begin
			nxt_data[cur_ff] = i_done.data;
			nxt_err[cur_ff]  = i_done.err;
			nxt_fin[cur_ff]  = 1'b1;
			nxt_occ[cur_ff]  = 1'b0;
		end
	end

	// dispatcher
	always_comb begin
		nxt_state    = state_ff;
		nxt_rr       = rr_ff;
		nxt_cur      = cur_ff;
		nxt_irq      = irq_ff;
		nxt_cmd      = cmd_ff;
		nxt_cmd.req  = 1'b0;
		nxt_sev      = sev_ff;
		nxt_int_mask = int_mask_ff;
		nxt_int      = int_ff;
		nxt_exc      = {i_exc_misaligned, i_exc_queue_ovf, i_exc_event_int,
			i_exc_data_access};
		if (wr_ok && direct && i_bus_addr[11:0] == CTRL_INT_MASK)
			nxt_int_mask = i_bus_wdata[NUM_IRQ-1:0];
		unique case (state_ff)
			ST_IDLE: begin
				if ((|taken) || run_found)
					nxt_state = ST_WAKE;
			end
			ST_WAKE: begin
				nxt_state = ST_IDLE;
				if (|taken) begin
					for (int i = NUM_IRQ - 1; i >= 0; i--)
						if (taken[i])
							nxt_irq = IRQ_W'(i);
					nxt_state = ST_IRQ;
				end else if (run_found) begin
					nxt_cur   = run_idx;
					nxt_state = ST_EXEC;
					nxt_cmd.req   = 1'b1;
					nxt_cmd.slot  = run_idx;
					nxt_cmd.ctype = low_ff[run_idx][14:9];
					nxt_cmd.imm   = low_ff[run_idx][8:0];
					nxt_cmd.data  = data_ff[run_idx];
					nxt_cmd.ctx   = ctx_pick(ctx_vec_ff,
						low_ff[run_idx][CTX_SEL_LSB +: 2]);
				end
			end
			ST_EXEC: begin
				if (i_done.valid) begin
					nxt_rr    = cur_ff + SLOT_W'(1);
					nxt_state = ST_IDLE;
				end
			end
			ST_IRQ: begin
				nxt_sev.req  = 1'b1;
				nxt_sev.addr = irq_base_ff + {26'h0000000, irq_ff, 3'h0};
				nxt_sev.data = EVT_READY;
				nxt_sev.ctx  = CTX_ZERO;
				if (sev_ff.req && i_set_event_ack) begin
					nxt_sev.req           = 1'b0;
					nxt_int_mask[irq_ff]  = 1'b0;
					nxt_state             = ST_IDLE;
				end
			end
		endcase
		nxt_busy = (nxt_state != ST_IDLE);
		// three-stage synchroniser on the pins, change counted once stages agree
		if (int_sync2_ff == int_sync3_ff)
			nxt_int = int_sync3_ff;
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			for (int s = 0; s < NUM_SLOTS; s++) begin
				data_ff[s] <= RST_WORD;
				low_ff[s]  <= '0;
			end
			occ_ff       <= '0;
			fin_ff       <= '0;
			err_ff       <= '0;
			irq_base_ff  <= RST_WORD;
			ctx_vec_ff   <= '0;
			int_mask_ff  <= '0;
			int_sync1_ff <= '0;
			int_sync2_ff <= '0;
			int_sync3_ff <= '0;
			int_ff       <= '0;
			state_ff     <= ST_IDLE;
			rr_ff        <= '0;
			cur_ff       <= '0;
			irq_ff       <= '0;
			ack_ff       <= 1'b0;
			rdata_ff     <= '0;
			cmd_ff       <= '0;
			sev_ff       <= '0;
			exc_ff       <= '0;
			swap_ff       <= 1'b0;
			swap_found_ff <= 1'b0;
			swap_idx_ff   <= '0;
			busy_ff       <= 1'b0;
		end else begin
			data_ff      <= nxt_data;
			low_ff       <= nxt_low;
			occ_ff       <= nxt_occ;
			fin_ff       <= nxt_fin;
			err_ff       <= nxt_err;
			irq_base_ff  <= nxt_irq_base;
			ctx_vec_ff   <= nxt_ctx_vec;
			int_mask_ff  <= nxt_int_mask;
			int_sync1_ff <= i_int_req;
			int_sync2_ff <= int_sync1_ff;
			int_sync3_ff <= int_sync2_ff;
			int_ff       <= nxt_int;
			state_ff     <= nxt_state;
			rr_ff        <= nxt_rr;
			cur_ff       <= nxt_cur;
			irq_ff       <= nxt_irq;
			ack_ff       <= nxt_ack;
			rdata_ff     <= nxt_rdata;
			cmd_ff       <= nxt_cmd;
			sev_ff       <= nxt_sev;
			exc_ff       <= nxt_exc;
			swap_ff       <= nxt_swap;
			swap_found_ff <= nxt_swap_found;
			swap_idx_ff   <= nxt_swap_idx;
			busy_ff       <= nxt_busy;
		end
	end

	// the dispatch strobe and status are registered; occupancy bits mirror the store
	assign o_bus_ack       = ack_ff;
	assign o_bus_rdata     = rdata_ff;
	assign o_cmd           = cmd_ff;
	assign o_set_event     = sev_ff;
	assign o_exception     = exc_ff;
	assign o_slot_occupied = occ_ff;
	assign o_busy          = busy_ff;
endmodule : command_port_processor

/* dv/cpp_sva.sv */
/* port checker for the command port processor.
 assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/1ns
module cpp_sva
	import cmd_port_pkg::*;
(
	input wire logic                 i_clk,
	input wire logic                 i_rst_n,
	input wire logic                 i_bus_sel,
	input wire logic                 i_bus_wr,
	input wire logic [3:0]           i_bus_be,
	input wire logic [REGION_AW-1:0] i_bus_addr,
	input wire logic                 o_bus_ack,
	input wire cmd_req_t             o_cmd,
	input wire cmd_done_t            i_done,
	input wire set_event_t           o_set_event,
	input wire logic                 i_set_event_ack,
	input wire logic                 i_exc_data_access,
	input wire logic                 i_exc_event_int,
	input wire logic                 i_exc_queue_ovf,
	input wire logic                 i_exc_misaligned,
	input wire logic [3:0]           o_exception,
	input wire logic [NUM_SLOTS-1:0] o_slot_occupied
);
	wire [3:0] exc_in = {i_exc_misaligned, i_exc_queue_ovf, i_exc_event_int, i_exc_data_access};
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// a done pulse in the same cycle may free a slot, so such cycles are skipped
	sequence s_issue_wr;
		i_bus_sel && i_bus_wr && i_bus_addr[17:12] != 6'h00 && !i_done.valid;
	endsequence
	property p_ack; 1 |=> o_bus_ack == $past(i_bus_sel); endproperty
	property p_issue;
		s_issue_wr ##0 (i_bus_be == 4'hf && !(&o_slot_occupied))
			|=> (o_slot_occupied & ~$past(o_slot_occupied)) != '0;
	endproperty
	property p_full; s_issue_wr ##0 (&o_slot_occupied) |=> o_slot_occupied == '1; endproperty
	property p_part; s_issue_wr ##0 (i_bus_be != 4'hf) |=> $stable(o_slot_occupied); endproperty
	property p_done; i_done.valid |=> !o_slot_occupied[$past(o_cmd.slot)]; endproperty
	property p_exc; 1 |=> o_exception == $past(exc_in); endproperty
	property p_evt;
		o_set_event.req |-> o_set_event.ctx == CTX_ZERO && o_set_event.data == EVT_READY;
	endproperty
	property p_evt_hold;
		o_set_event.req && !i_set_event_ack |=> o_set_event.req && $stable(o_set_event.addr);
	endproperty
	a_ack: assert property (p_ack) else $error("bus ack wrong");
	a_issue: assert property (p_issue) else $error("issue write set no slot");
	a_full: assert property (p_full) else $error("full issue write changed state");
	a_part: assert property (p_part) else $error("partial issue write changed state");
	a_done: assert property (p_done) else $error("slot not freed on done");
	a_exc: assert property (p_exc) else $error("exception not passed on");
	a_evt: assert property (p_evt) else $error("set-event fields wrong");
	a_evt_hold: assert property (p_evt_hold) else $error("set-event dropped");
endmodule : cpp_sva
bind command_port_processor cpp_sva u_sva (
	.i_clk, .i_rst_n, .i_bus_sel, .i_bus_wr, .i_bus_be, .i_bus_addr, .o_bus_ack, .o_cmd,
	.i_done, .o_set_event, .i_set_event_ack, .i_exc_data_access, .i_exc_event_int,
	.i_exc_queue_ovf, .i_exc_misaligned, .o_exception, .o_slot_occupied
);

/* dv/cmd_exec_model.sv */
/* command executor and set-event agent facing the command port.
 assumes one command in flight; i_hold stalls the result indefinitely. */
`timescale 1ns/1ns
module cmd_exec_model
	import cmd_port_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_hold,
	input  wire cmd_req_t   i_cmd,
	input  wire set_event_t i_sev,
	output cmd_done_t       o_done,
	output logic            o_sev_ack
);
	logic [31:0] res_ff = '0;
	logic [1:0]  cnt_ff = '0;
	logic        pend_ff = 1'b0;
	initial o_done = '0;
	initial o_sev_ack = 1'b0;
	always @(posedge i_clk) begin
		// data between results is inverted so a stale word never looks valid
		o_done <= {2'b00, ~res_ff};
		o_sev_ack <= i_sev.req && !o_sev_ack;
		if (i_cmd.req) begin
			pend_ff <= 1'b1;
			cnt_ff <= 2'h3;
			res_ff <= i_cmd.data + 32'h1;
		end else if (pend_ff && !i_hold) begin
			cnt_ff <= cnt_ff - 2'h1;
			if (cnt_ff == 2'h0) begin
				pend_ff <= 1'b0;
				o_done <= {1'b1, 1'b0, res_ff};
			end
		end
	end
endmodule : cmd_exec_model

/* dv/tb.sv */
/* self-checking bench for the command port processor.
 assumes the executor model on the far side and a 25 MHz clock. */
`timescale 1ns/1ns
module tb;
	import cmd_port_pkg::*;
	logic i_clk = 0, i_rst_n = 0, sel = 0, wr = 0, read_modify_write_swap = 0, hold = 0, ack, sev_ack, busy;
	logic [3:0] be = 4'hf, exc = 4'h0, occ, exo;
	logic [17:0] addr = '0;
	logic [31:0] wdata = '0, rd, rdata;
	logic [7:0] irq = '0;
	cmd_req_t cmd;
	cmd_done_t done;
	set_event_t sev;
	cmd_req_t cq[$];
	logic [31:0] sq[$];
	int num_errors = 0, n_checks = 0, cyc = 0;
	always #20 i_clk = ~i_clk;
	command_port_processor dut (.i_clk, .i_rst_n, .i_bus_sel(sel), .i_bus_wr(wr),
		.i_bus_rmw(read_modify_write_swap), .i_bus_be(be), .i_bus_addr(addr), .i_bus_wdata(wdata),
		.o_bus_ack(ack), .o_bus_rdata(rdata), .i_int_req(irq), .o_cmd(cmd), .i_done(done),
		.o_set_event(sev), .i_set_event_ack(sev_ack), .i_exc_data_access(exc[0]),
		.i_exc_event_int(exc[1]), .i_exc_queue_ovf(exc[2]), .i_exc_misaligned(exc[3]),
		.o_exception(exo), .o_slot_occupied(occ), .o_busy(busy));
	cmd_exec_model exec (.i_clk, .i_hold(hold), .i_cmd(cmd), .i_sev(sev), .o_done(done),
		.o_sev_ack(sev_ack));
	always @(posedge i_clk) begin
		cyc++;
		if (cmd.req === 1'b1)
			cq.push_back(cmd);
		if (sev.req === 1'b1 && sev_ack === 1'b1)
			sq.push_back(sev.addr);
		if (cyc == 6000) begin
			num_errors++;
			finish_test();
		end
	end
	task finish_test;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : finish_test
	task ck(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : ck
	// one access per call; sel drops after the taking edge, ack is seen a cycle on
	task bus(input logic w, input logic [3:0] b, input logic [17:0] a, input logic [31:0] d);
		@(negedge i_clk);
		sel = 1;
		wr = w;
		be = b;
		addr = a;
		wdata = d;
		@(negedge i_clk);
		sel = 0;
		rd = rdata;
		ck({31'h0, ack}, 32'h1);
	endtask : bus
	task wait_q(input int n, input logic ev);
		int i;
		i = 0;
		while ((ev ? sq.size() : cq.size()) < n && i < 300) begin
			@(negedge i_clk);
			i++;
		end
		ck(32'(ev ? sq.size() : cq.size()), 32'(n));
	endtask : wait_q
	task t_direct;
		bus(1, 4'hf, 18'h104, 32'h2222_1111);
		bus(1, 4'hf, 18'h108, 32'h4444_3333);
		bus(0, 4'hf, 18'h00c, 0);
		ck(rd, 32'h0);
		bus(1, 4'hf, 18'h008, 32'h0000_00a5);
		bus(1, 4'hf, 18'h00c, 32'h8000_0a02);
		wait_q(1, 0);
		ck({26'h0, cq[0].ctype}, 32'h5);
		ck({23'h0, cq[0].imm}, 32'h2);
		ck({16'h0, cq[0].ctx}, 32'h3333);
		ck({30'h0, cq[0].slot}, 32'h1);
		repeat (12) @(negedge i_clk);
		bus(0, 4'hf, 18'h008, 0);
		ck(rd, 32'ha6);
		bus(0, 4'hf, 18'h00c, 0);
		ck(rd & 32'hffff_8000, 32'h4000_0000);
		ck({31'h0, busy}, 32'h0);
	endtask : t_direct
	// executor stalled so the issue image fills up
	task t_issue;
		int k;
		logic [1:0] s;
		hold = 1;
		bus(1, 4'h3, 18'h030e0, 32'h55);
		ck({28'h0, occ}, 32'h0);
		for (k = 0; k < 4; k++) begin
			read_modify_write_swap = 1;
			bus(0, 4'hf, 18'h030e0, 0);
			ck(rd & 32'hffff_fffc, 32'h0);
			s = rd[1:0];
			ck(32'($countones(occ)), 32'(k));
			bus(1, 4'hf, 18'h030e0, 32'h10 + k);
			read_modify_write_swap = 0;
			ck({31'h0, occ[s]}, 32'h1);
			bus(0, 4'hf, {13'h0, s, 3'h4}, 0);
			ck(rd & 32'h8000_7fff, 32'h8000_061c);
		end
		read_modify_write_swap = 1;
		bus(0, 4'hf, 18'h030e0, 0);
		ck(rd, NO_SLOT);
		bus(1, 4'hf, 18'h030e0, 32'h99);
		read_modify_write_swap = 0;
		ck({28'h0, occ}, 32'hf);
		ck({31'h0, busy}, 32'h1);
		hold = 0;
		wait_q(5, 0);
		for (k = 1; k < 5; k++)
			ck(cq[k].data, 32'h0f + k);
		for (k = 1; k < 4; k++)
			ck({30'h0, cq[k + 1].slot}, {30'h0, cq[k].slot + 2'h1});
	endtask : t_issue
	task t_irq;
		bus(1, 4'hf, 18'h100, 32'h400);
		bus(1, 4'hf, 18'h10c, 32'h24);
		irq = 8'h22;
		wait_q(1, 1);
		repeat (12) @(negedge i_clk);
		ck(32'(sq.size()), 32'h1);
		ck(sq[0], 32'h428);
		bus(0, 4'hf, 18'h10c, 0);
		ck(rd, 32'h4);
		irq = 8'h00;
	endtask : t_irq
	task t_exc;
		int k;
		for (k = 0; k < 4; k++) begin
			@(negedge i_clk);
			exc = 4'h1 << k;
			@(negedge i_clk);
			exc = 4'h0;
			ck({28'h0, exo}, 32'h1 << k);
		end
	endtask : t_exc
	initial begin
		repeat (4) @(posedge i_clk);
		@(negedge i_clk);
		i_rst_n = 1;
		ck({28'h0, occ}, 32'h0);
		bus(0, 4'hf, 18'h004, 0);
		ck(rd, 32'h0);
		t_direct();
		t_issue();
		t_irq();
		t_exc();
		finish_test();
	end
endmodule : tb
